//--- logic/tcrb_bank.sv
// Tuner control register bank, addresses 0x09 to 0x0d plus ROM readback
//
// Behaviour
// (R1) Oscillator select 00 off, 01 lowest, 10 middle, 11 highest, in manual mode.
// (R2) Sub-band select bits 5..3 drive active sub-band in manual mode.
// (R3) Autotune bit 1 lets autotuner choose; 0 uses manual fields.
// (R4) Tuning converter latch follows bit 1 while autotune is off.
// (R5) Tuning converter read enable follows bit 0 while autotune is off.
// (R6) Filter bandwidth comes from bits 7..4 of baseband control.
// (R7) Baseband bit 3 selects high filter bias current.
// (R8) Bits 2..0 set detector attack point; 000 most aggressive.
// (R9) Host writes 0 to reserved bit 7 of offset control.
// (R10) Manual offset value is nine bits, msb from offset control bit 6.
// (R11) Mode 00 off, 01/10 manual value to DACs, 11 automatic.
// (R12) Speed 00 holds DACs, 01 slowest through 11 fastest.
// (R13) Threshold bits 1..0 pick accuracy; host avoids code 00.
// (R14) Low eight bits of manual value come from offset value register.
// (R15) Host writes 0000 into reserved upper bits of ROM address.
// (R16) ROM address selects notch, balun or bandwidth entry; others reserved.
// (R17) Selected ROM entry appears at readback address 0x10.
// (R18) Main bias off only when shutdown all ones, oscillator and mode 00; code tests the manual oscillator field, not the autotuner choice.
// (R19) Registers hold last written value; reserved bits stored, no effect.
`timescale 1ns/1ps
`default_nettype none
`include "tcrb_map.svh"
module tcrb_bank #(
  parameter logic [7:0] NOTCH_COEF = 8'h00,
  parameter logic [7:0] BALUN_COEF = 8'h00,
  parameter logic [7:0] BW_SETTING = 8'h00
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic shutdown_all,
  input wire logic autotune_osc_valid,
  input wire logic [1:0] autotune_osc,
  input wire logic [2:0] autotune_subband,
  output logic [1:0] oscillator_select,
  output logic [2:0] subband_select,
  output logic autotune_enable,
  output logic tuning_adc_latch,
  output logic tuning_adc_read_enable,
  output logic [3:0] filter_bandwidth,
  output logic filter_bias_high,
  output logic [2:0] detector_attack_point,
  output logic [1:0] offset_correction_mode,
  output logic [1:0] offset_correction_speed,
  output logic [1:0] offset_accuracy_threshold,
  output logic offset_manual_drive,
  output logic offset_hold,
  output logic [8:0] offset_dac_value,
  output logic [3:0] rom_entry_address,
  output logic [7:0] rom_entry_readback,
  output logic main_bias_off
);
  logic rst_s1_q;
  logic rst_n;
  logic [7:0] osc_q;
  logic [7:0] bb_q;
  logic [7:0] ofs_q;
  logic [7:0] ofslo_q;
  logic [7:0] roma_q;
  logic [7:0] rd_d;
  logic [8:0] dac_d;
  logic [1:0] osc_d;
  logic [2:0] sb_d;
  logic auto_w;
  logic man_w;
  logic ofs_on_w;
  logic hit_w;
  logic [1:0] man_osc_w;
  logic [2:0] man_sb_w;
  logic [8:0] man_val_w;
  tcrb_pkg::tcrb_ofs_mode_t mode_w;
  // Next values of the output flops
  logic auto_d;
  logic latch_d;
  logic rden_d;
  logic [3:0] bw_d;
  logic bias_d;
  logic [2:0] pd_d;
  logic [1:0] mode_d;
  logic [1:0] spd_d;
  logic hold_d;
  logic [1:0] th_d;
  logic mdrv_d;
  logic [3:0] roma_d;
  logic bias_off_d;
  localparam int NREG = 5;
  // Reset value of each register, in address order
  localparam logic [7:0] RST_VAL [NREG] = '{`TCRB_RST_OSC, `TCRB_RST_BB, `TCRB_RST_OFS,
                                             `TCRB_RST_OFSLO, `TCRB_RST_ROMA};
  logic [7:0] regs_q [NREG];
  logic [5:0] sel_w;
  logic [NREG-1:0] wr_en_w;

  // Reset released through two flops so release is clean in clk domain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // One-hot address decode shared by write enables, hit flag and read mux
  function automatic logic [5:0] decode_addr(logic [7:0] a);
    logic [5:0] s;
    s = 6'h00;
    if (a == `TCRB_ADDR_OSC) begin
      s = 6'h01;
    end else if (a == `TCRB_ADDR_BB) begin
      s = 6'h02;
    end else if (a == `TCRB_ADDR_OFS) begin
      s = 6'h04;
    end else if (a == `TCRB_ADDR_OFSLO) begin
      s = 6'h08;
    end else if (a == `TCRB_ADDR_ROMA) begin
      s = 6'h10;
    end else if (a == `TCRB_ADDR_ROMD) begin
      s = 6'h20;
    end
    return s;
  endfunction

  // Writes to 0x10 or unmapped addresses drop; reserved bits are stored [R19] [R9] [R15]
  assign sel_w = decode_addr(reg_addr);
  assign wr_en_w = {NREG{reg_wr}} & sel_w[NREG-1:0];
  // Registers live in an array so every byte shares one write path
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        regs_q[g] <= RST_VAL[g];
      end else if (wr_en_w[g]) begin
        regs_q[g] <= reg_wdata;
      end
    end
  end
  assign osc_q = regs_q[0];
  assign bb_q = regs_q[1];
  assign ofs_q = regs_q[2];
  assign ofslo_q = regs_q[3];
  assign roma_q = regs_q[4];

  // Read selection, registered so data settles one cycle after address
  assign hit_w = |sel_w;
  assign reg_hit = hit_w;
  assign rd_d = sel_w[0] ? osc_q :
                sel_w[1] ? bb_q :
                sel_w[2] ? ofs_q :
                sel_w[3] ? ofslo_q :
                sel_w[4] ? roma_q :
                sel_w[5] ? rom_entry_readback : 8'h00; // [R17]

  // Field extraction
  assign auto_w = osc_q[`TCRB_AUTO_BIT];
  assign man_osc_w = osc_q[`TCRB_OSC_SEL_HI:`TCRB_OSC_SEL_LO];
  assign man_sb_w = osc_q[`TCRB_SB_HI:`TCRB_SB_LO];
  assign mode_w = tcrb_pkg::tcrb_ofs_mode_t'(ofs_q[`TCRB_MODE_HI:`TCRB_MODE_LO]); // [R11]
  assign man_val_w = {ofs_q[`TCRB_MSB_BIT], ofslo_q}; // [R10] [R14]

  // Autotuner choice overrides manual fields only when enabled
  assign osc_d = (auto_w && autotune_osc_valid) ? autotune_osc : man_osc_w; // [R1] [R3]
  assign sb_d = (auto_w && autotune_osc_valid) ? autotune_subband : man_sb_w; // [R2] [R3]
  // Offset mode decode: manual drive in modes 01 and 10, correction on unless 00
  assign man_w = (mode_w == tcrb_pkg::TCRB_OFS_MAN_A) || (mode_w == tcrb_pkg::TCRB_OFS_MAN_B); // [R11]
  assign ofs_on_w = (mode_w != tcrb_pkg::TCRB_OFS_OFF); // [R11]
  // DAC follows manual value only in manual modes; otherwise left at zero
  assign dac_d = man_w ? man_val_w : 9'h000; // [R11]

  assign auto_d = auto_w; // [R3]
  assign latch_d = !auto_w && osc_q[`TCRB_LATCH_BIT]; // [R4]
  assign rden_d = !auto_w && osc_q[`TCRB_READ_BIT]; // [R5]
  assign bw_d = bb_q[`TCRB_BW_HI:`TCRB_BW_LO]; // [R6]
  assign bias_d = bb_q[`TCRB_BIAS_BIT]; // [R7]
  assign pd_d = bb_q[`TCRB_PD_HI:`TCRB_PD_LO]; // [R8]
  assign mode_d = ofs_q[`TCRB_MODE_HI:`TCRB_MODE_LO]; // [R11]
  assign spd_d = ofs_q[`TCRB_SPD_HI:`TCRB_SPD_LO]; // [R12]
  // Speed 00 freezes the loop while correction stays enabled
  assign hold_d = ofs_on_w && (spd_d == 2'h0); // [R12]
  assign th_d = ofs_q[`TCRB_TH_HI:`TCRB_TH_LO]; // [R13]
  assign mdrv_d = man_w; // [R11]
  // Upper reserved bits never reach the ROM
  assign roma_d = roma_q[`TCRB_ROMA_HI:`TCRB_ROMA_LO]; // [R16]
  assign bias_off_d = shutdown_all && (man_osc_w == tcrb_pkg::TCRB_OSC_OFF) && !ofs_on_w; // [R18]

  // Flopped so analog controls never see decode glitches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscillator_select <= 2'h0;
    end else begin
      oscillator_select <= osc_d; // [R1]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      subband_select <= 3'h0;
    end else begin
      subband_select <= sb_d; // [R2]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      autotune_enable <= 1'b0;
    end else begin
      autotune_enable <= auto_d; // [R3]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tuning_adc_latch <= 1'b0;
    end else begin
      tuning_adc_latch <= latch_d; // [R4]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tuning_adc_read_enable <= 1'b0;
    end else begin
      tuning_adc_read_enable <= rden_d; // [R5]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_bandwidth <= 4'h0;
    end else begin
      filter_bandwidth <= bw_d; // [R6]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_bias_high <= 1'b0;
    end else begin
      filter_bias_high <= bias_d; // [R7]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detector_attack_point <= 3'h0;
    end else begin
      detector_attack_point <= pd_d; // [R8]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_correction_mode <= 2'h0;
    end else begin
      offset_correction_mode <= mode_d; // [R11]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_correction_speed <= 2'h0;
    end else begin
      offset_correction_speed <= spd_d; // [R12]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_hold <= 1'b0;
    end else begin
      offset_hold <= hold_d; // [R12]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_accuracy_threshold <= 2'h0;
    end else begin
      offset_accuracy_threshold <= th_d; // [R13]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_manual_drive <= 1'b0;
    end else begin
      offset_manual_drive <= mdrv_d; // [R11]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_dac_value <= 9'h000;
    end else begin
      offset_dac_value <= dac_d; // [R10] [R14]
    end
  end

  // Same address reaches the ROM one cycle earlier, so readback lines up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_entry_address <= 4'h0;
    end else begin
      rom_entry_address <= roma_d; // [R16]
    end
  end

  // Bias may only drop once shutdown_all is set and the manual oscillator field and offset mode are both 00
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_bias_off <= 1'b0;
    end else begin
      main_bias_off <= bias_off_d; // [R18]
    end
  end

  // Read data lags the address by one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rd_d;
    end
  end

  tcrb_rom #(
    .NOTCH_COEF(NOTCH_COEF),
    .BALUN_COEF(BALUN_COEF),
    .BW_SETTING(BW_SETTING)
  ) u_rom (
    .clk(clk),
    .rst_n(rst_n),
    .addr(roma_q[`TCRB_ROMA_HI:`TCRB_ROMA_LO]), // [R16]
    .rdata(rom_entry_readback) // [R17]
  );
endmodule
`default_nettype wire

//--- logic/tcrb_map.svh
// Register offsets, field positions and reset values of the tuner control bank
`ifndef TCRB_MAP_SVH
`define TCRB_MAP_SVH
`define TCRB_ADDR_OSC 8'h09
`define TCRB_ADDR_BB 8'h0a
`define TCRB_ADDR_OFS 8'h0b
`define TCRB_ADDR_OFSLO 8'h0c
`define TCRB_ADDR_ROMA 8'h0d
`define TCRB_ADDR_ROMD 8'h10
`define TCRB_RST_OSC 8'h00
`define TCRB_RST_BB 8'h00
`define TCRB_RST_OFS 8'h00
`define TCRB_RST_OFSLO 8'h00
`define TCRB_RST_ROMA 8'h00
`define TCRB_OSC_SEL_HI 7
`define TCRB_OSC_SEL_LO 6
`define TCRB_SB_HI 5
`define TCRB_SB_LO 3
`define TCRB_AUTO_BIT 2
`define TCRB_LATCH_BIT 1
`define TCRB_READ_BIT 0
`define TCRB_BW_HI 7
`define TCRB_BW_LO 4
`define TCRB_BIAS_BIT 3
`define TCRB_PD_HI 2
`define TCRB_PD_LO 0
`define TCRB_MSB_BIT 6
`define TCRB_MODE_HI 5
`define TCRB_MODE_LO 4
`define TCRB_SPD_HI 3
`define TCRB_SPD_LO 2
`define TCRB_TH_HI 1
`define TCRB_TH_LO 0
`define TCRB_ROMA_HI 3
`define TCRB_ROMA_LO 0
`endif

//--- logic/tcrb_pkg.sv
// Types shared by the tuner control register bank
`default_nettype none
package tcrb_pkg;
  typedef enum logic [1:0] {
    TCRB_OSC_OFF = 2'b00,
    TCRB_OSC_LOW = 2'b01,
    TCRB_OSC_MID = 2'b10,
    TCRB_OSC_HIGH = 2'b11
  } tcrb_osc_t;
  typedef enum logic [1:0] {
    TCRB_OFS_OFF = 2'b00,
    TCRB_OFS_MAN_A = 2'b01,
    TCRB_OFS_MAN_B = 2'b10,
    TCRB_OFS_AUTO = 2'b11
  } tcrb_ofs_mode_t;
  typedef enum logic [3:0] {
    TCRB_ROM_NONE = 4'h0,
    TCRB_ROM_NOTCH = 4'h1,
    TCRB_ROM_BALUN = 4'h2,
    TCRB_ROM_BW = 4'h3
  } tcrb_rom_entry_t;
endpackage
`default_nettype wire

//--- logic/tcrb_rom.sv
// Calibration ROM with registered read data
`timescale 1ns/1ps
`default_nettype none
module tcrb_rom #(
  parameter logic [7:0] NOTCH_COEF = 8'h00,
  parameter logic [7:0] BALUN_COEF = 8'h00,
  parameter logic [7:0] BW_SETTING = 8'h00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  output logic [7:0] rdata
);
  logic [7:0] word;
  // Reserved entries read as zero
  assign word = (addr == tcrb_pkg::TCRB_ROM_NOTCH) ? NOTCH_COEF :
                (addr == tcrb_pkg::TCRB_ROM_BALUN) ? BALUN_COEF :
                (addr == tcrb_pkg::TCRB_ROM_BW) ? BW_SETTING : 8'h00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= word;
    end
  end
endmodule
`default_nettype wire

//--- tb/tcrb_chk.sv
// Port assertions for the tuner control bank
`timescale 1ns/1ps
`default_nettype none
module tcrb_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic shutdown_all,
  input wire logic autotune_osc_valid,
  input wire logic [1:0] autotune_osc,
  input wire logic [2:0] autotune_subband,
  input wire logic [1:0] oscillator_select,
  input wire logic [2:0] subband_select,
  input wire logic autotune_enable,
  input wire logic tuning_adc_latch,
  input wire logic tuning_adc_read_enable,
  input wire logic [3:0] filter_bandwidth,
  input wire logic filter_bias_high,
  input wire logic [2:0] detector_attack_point,
  input wire logic [1:0] offset_correction_mode,
  input wire logic [1:0] offset_correction_speed,
  input wire logic offset_manual_drive,
  input wire logic offset_hold,
  input wire logic [3:0] rom_entry_address,
  input wire logic [7:0] rom_entry_readback,
  input wire logic main_bias_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Derived outputs trail the write edge by two samples
  a_osc_manual: assert property (reg_wr && reg_addr == 8'h09 && !reg_wdata[2] |->
    ##2 oscillator_select == $past(reg_wdata[7:6], 2)) else $error("manual oscillator wrong");
  a_adc_gate: assert property (autotune_enable |-> !tuning_adc_latch && !tuning_adc_read_enable)
    else $error("converter not gated");
  a_auto_pick: assert property (autotune_enable && $past(autotune_osc_valid) |->
    {oscillator_select, subband_select} == $past({autotune_osc, autotune_subband})) else $error("autotune choice wrong");
  a_bb_fields: assert property (reg_wr && reg_addr == 8'h0a |->
    ##2 {filter_bandwidth, filter_bias_high, detector_attack_point} == $past(reg_wdata, 2)) else $error("baseband wrong");
  a_drive_mode: assert property (offset_manual_drive == (offset_correction_mode inside {2'h1, 2'h2}))
    else $error("manual drive wrong");
  a_hold_speed: assert property (
    offset_hold == (offset_correction_mode != 2'h0 && offset_correction_speed == 2'h0)) else $error("hold wrong");
  a_bias_cause: assert property (main_bias_off |-> offset_correction_mode == 2'h0 && $past(shutdown_all))
    else $error("bias off early");
  a_rom_addr: assert property (reg_wr && reg_addr == 8'h0d |->
    ##2 rom_entry_address == $past(reg_wdata[3:0], 2)) else $error("rom address wrong");
  a_readback: assert property ($past(reg_addr) == 8'h10 |-> reg_rdata == $past(rom_entry_readback))
    else $error("readback wrong");
endmodule
bind tcrb_bank tcrb_chk chk (.*);
`default_nettype wire

//--- tb/tcrb_host.sv
// Host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module tcrb_host (
  input wire logic clk,
  output logic reg_wr = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  input wire logic [7:0] reg_rdata
);
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    // Reserved bits go out as zero so they never steer the bank
    reg_wdata <= a == 8'h0b ? d & 8'h7f : a == 8'h0d ? d & 8'h0f : d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- tb/test_tcrb_bank.sv
// Self-checking bench for the tuner control register bank
`timescale 1ns/1ps
`default_nettype none
module test_tcrb_bank;
  logic clk = 1'b0, nrst = 1'b0, shutdown_all = 1'b1, autotune_osc_valid = 1'b0;
  logic [1:0] autotune_osc = 2'h0;
  logic [2:0] autotune_subband = 3'h0;
  wire reg_wr, reg_hit, autotune_enable, tuning_adc_latch, tuning_adc_read_enable;
  wire filter_bias_high, offset_manual_drive, offset_hold, main_bias_off;
  wire [1:0] oscillator_select, offset_correction_mode, offset_correction_speed, offset_accuracy_threshold;
  wire [2:0] subband_select, detector_attack_point;
  wire [3:0] filter_bandwidth, rom_entry_address;
  wire [7:0] reg_addr, reg_wdata, reg_rdata, rom_entry_readback;
  wire [8:0] offset_dac_value;
  logic [7:0] rv, d;
  // Reserved ROM codes read as zero
  logic [7:0] rom_v [5] = '{8'h00, 8'h3c, 8'h5a, 8'hc3, 8'h00};
  int n_fail, n_tests, cyc;
  tcrb_bank #(.NOTCH_COEF(8'h3c), .BALUN_COEF(8'h5a), .BW_SETTING(8'hc3)) uut (.*);
  tcrb_host host (.*);
  task automatic chk(string s, logic [8:0] e, logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_rst();
    for (int a = 9; a < 15; a++) begin
      host.rd(8'(a), rv);
      chk("reset", 9'h000, {1'b0, rv});
      chk("hit", {8'h00, a != 14}, {8'h00, reg_hit});
    end
  endtask
  task automatic t_osc();
    for (int i = 0; i < 8; i++) begin
      d = {i[1:0], 3'(7 - i), i[2], 2'h3};
      host.wr(8'h09, d);
      repeat (2) @(negedge clk);
      chk("osc", {3'h0, d[7:2]}, {3'h0, oscillator_select, subband_select, autotune_enable});
      chk("adc", i[2] ? 9'h000 : 9'h003, {7'h00, tuning_adc_latch, tuning_adc_read_enable});
      chk("bias", {8'h00, d[7:6] == 2'h0}, {8'h00, main_bias_off});
      host.rd(8'h09, rv);
      chk("osc reg", {1'b0, d}, {1'b0, rv});
    end
  endtask
  task automatic t_auto();
    host.wr(8'h09, 8'h2e);
    @(posedge clk);
    autotune_osc_valid <= 1'b1;
    autotune_osc <= 2'h3;
    autotune_subband <= 3'h2;
    shutdown_all <= 1'b0;
    repeat (2) @(negedge clk);
    chk("auto osc", 9'h035, {3'h0, oscillator_select, subband_select, autotune_enable});
    chk("auto adc", 9'h000, {7'h00, tuning_adc_latch, tuning_adc_read_enable});
    chk("bias on", 9'h000, {8'h00, main_bias_off});
    @(posedge clk);
    autotune_osc_valid <= 1'b0;
    shutdown_all <= 1'b1;
    repeat (2) @(negedge clk);
    chk("auto idle", 9'h00b, {3'h0, oscillator_select, subband_select, autotune_enable});
    chk("bias off", 9'h001, {8'h00, main_bias_off});
  endtask
  task automatic t_bb();
    foreach (rom_v[i]) begin
      host.wr(8'h0a, rom_v[i]);
      repeat (2) @(negedge clk);
      chk("bb", {1'b0, rom_v[i]}, {1'b0, filter_bandwidth, filter_bias_high, detector_attack_point});
    end
  endtask
  task automatic t_ofs();
    logic [1:0] m;
    host.wr(8'h0c, 8'ha5);
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      // Threshold code 00 is never used
      d = {2'h3, m, ~m, m | {1'b0, m == 2'h0}};
      host.wr(8'h0b, d);
      repeat (2) @(negedge clk);
      chk("ofs", {3'h0, d[5:0]}, {3'h0, offset_correction_mode, offset_correction_speed,
        offset_accuracy_threshold});
      chk("drv", {7'h00, ^m, &m}, {7'h00, offset_manual_drive, offset_hold});
      chk("dac", ^m ? 9'h1a5 : 9'h000, offset_dac_value);
      chk("bias mode", {8'h00, m == 2'h0}, {8'h00, main_bias_off});
    end
    host.rd(8'h0b, rv);
    chk("ofs reg", 9'h073, {1'b0, rv});
  endtask
  task automatic t_rom();
    foreach (rom_v[i]) begin
      host.wr(8'h0d, 8'(i) | 8'hf0);
      repeat (2) @(negedge clk);
      host.rd(8'h10, rv);
      chk("rom", {1'b0, rom_v[i]}, {1'b0, rv});
      chk("rom out", {1'b0, rom_v[i]}, {1'b0, rom_entry_readback});
      chk("hit rom", 9'h001, {8'h00, reg_hit});
      chk("rom addr", 9'(i), {5'h00, rom_entry_address});
    end
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_rst();
    t_osc();
    t_auto();
    t_bb();
    t_ofs();
    t_rom();
    report_and_stop();
  end
endmodule
`default_nettype wire
